// ### rtl/fsl_pkg.sv
package fsl_pkg;

  localparam int unsigned ADDR_W     = 6;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FRAME_W    = 16;
  localparam int unsigned SW_W       = 8;
  localparam int unsigned SUP_W      = 4;
  localparam int unsigned RAW_W      = SW_W + SUP_W;
  localparam int unsigned LOCK_W     = 3;
  localparam int unsigned CNT_W      = 5;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_IC_STATUS     = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_SWITCH_STATUS = 6'h01;
  localparam logic [ADDR_W-1:0] OFS_SUPPLY_STATUS = 6'h02;
  localparam logic [ADDR_W-1:0] OFS_WRITE_LOCK    = 6'h03;
  localparam logic [ADDR_W-1:0] OFS_CFG_B         = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_CFG_C         = 6'h05;
  localparam logic [ADDR_W-1:0] OFS_CFG_D         = 6'h06;
  localparam logic [ADDR_W-1:0] OFS_CFG_E         = 6'h07;
  localparam logic [ADDR_W-1:0] OFS_CFG_F         = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_CFG_J         = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_LAST          = 6'h0C;

  // Reset values
  localparam logic [DATA_W-1:0] RST_STATUS = 8'h00;
  localparam logic [LOCK_W-1:0] RST_LOCK   = 3'h0;
  localparam logic [DATA_W-1:0] RST_CFG_B  = 8'h60;
  localparam logic [DATA_W-1:0] RST_CFG_C  = 8'h46;
  localparam logic [DATA_W-1:0] RST_CFG_D  = 8'h10;
  localparam logic [DATA_W-1:0] RST_CFG_E  = 8'h00;
  localparam logic [DATA_W-1:0] RST_CFG_F  = 8'h00;
  localparam logic [DATA_W-1:0] RST_CFG_J  = 8'h00;

  // Thermal and switch status fields
  localparam int unsigned BIT_TW = 7;
  localparam int unsigned BIT_TS = 6;
  localparam int unsigned OC_W   = 6;

  // Supply and serial status fields
  localparam int unsigned BIT_OTP      = 6;
  localparam int unsigned BIT_SD_OC    = 5;
  localparam int unsigned BIT_SD_UV    = 4;
  localparam int unsigned BIT_CP_LOW   = 3;
  localparam int unsigned BIT_PARITY   = 2;
  localparam int unsigned BIT_FRAMING  = 1;
  localparam int unsigned BIT_BAD_ADDR = 0;

  // Summary status fields
  localparam int unsigned IC_BUCK   = 6;
  localparam int unsigned IC_SERIAL = 5;
  localparam int unsigned IC_OC     = 4;
  localparam int unsigned IC_OT     = 1;
  localparam int unsigned IC_FAULT  = 0;

  // Lock codes and config fields
  localparam logic [LOCK_W-1:0] LOCK_UNLOCK      = 3'h3;
  localparam logic [LOCK_W-1:0] LOCK_LOCK        = 3'h6;
  localparam int unsigned       BIT_CLEAR_FAULTS = 0;
  localparam int unsigned       BIT_SDO_PP       = 5;
  localparam logic [DATA_W-1:0] CFG_C_WMASK      = 8'h7F;

  // Frame layout
  localparam int unsigned       FRM_RW      = 15;
  localparam int unsigned       FRM_ADDR_HI = 14;
  localparam int unsigned       FRM_ADDR_LO = 9;
  localparam logic [CNT_W-1:0]  FRAME_CNT   = 5'h10;
  localparam logic [CNT_W-1:0]  STATUS_CNT  = 5'h08;
  localparam logic [CNT_W-1:0]  CNT_MAX     = 5'h1F;
  localparam logic [2:0]        PIN_IDLE    = 3'h2;

  typedef struct packed {
    logic [RAW_W-1:0]  flt_s1;
    logic [RAW_W-1:0]  flt_s2;
    logic              slp_s1;
    logic              slp_s2;
    logic [DATA_W-1:0] switch_status;
    logic [DATA_W-1:0] supply_status;
    logic [LOCK_W-1:0] lock_field;
    logic [DATA_W-1:0] cfg_b;
    logic [DATA_W-1:0] cfg_c;
    logic [DATA_W-1:0] cfg_d;
    logic [DATA_W-1:0] cfg_e;
    logic [DATA_W-1:0] cfg_f;
    logic [DATA_W-1:0] cfg_j;
  } fsl_regs_s;

  localparam fsl_regs_s REGS_RST = '{
    flt_s1: '0, flt_s2: '0, slp_s1: 1'b0, slp_s2: 1'b0,
    switch_status: RST_STATUS, supply_status: RST_STATUS, lock_field: RST_LOCK,
    cfg_b: RST_CFG_B, cfg_c: RST_CFG_C, cfg_d: RST_CFG_D,
    cfg_e: RST_CFG_E, cfg_f: RST_CFG_F, cfg_j: RST_CFG_J};

  typedef struct packed {
    logic [2:0]         pin_s1;
    logic [2:0]         pin_s2;
    logic [1:0]         pin_s3;
    logic               active;
    logic [CNT_W-1:0]   cnt;
    logic [FRAME_W-1:0] rx;
    logic [DATA_W-1:0]  tx;
    logic               done;
    logic               err;
  } fsl_frame_s;

  localparam fsl_frame_s FRAME_RST = '{
    pin_s1: PIN_IDLE, pin_s2: PIN_IDLE, pin_s3: PIN_IDLE[2:1], active: 1'b0,
    cnt: '0, rx: '0, tx: '0, done: 1'b0, err: 1'b0};

endpackage : fsl_pkg

// ### rtl/fsl_serial_frame.sv
module fsl_serial_frame
  import fsl_pkg::*;
(
  input  logic                core_clk_i,
  input  logic                reset_i,
  input  logic                sclk_i,
  input  logic                scs_n_i,
  input  logic                sdi_i,
  input  logic                sdo_push_pull_i,
  input  logic [DATA_W-1:0]   status_byte_i,
  input  logic [DATA_W-1:0]   rd_data_i,
  output logic [ADDR_W-1:0]   rd_addr_o,
  output logic                frame_done_o,
  output logic [FRAME_W-1:0]  frame_word_o,
  output logic                frame_err_o,
  output logic                sdo_o,
  output logic                sdo_oe_o
);

  fsl_frame_s st_reg;
  fsl_frame_s st_next;
  logic       sclk_fall;
  logic       sclk_rise;
  logic       cs_fall;
  logic       cs_rise;

  // Pin order {sclk, cs_n, sdi}; stages two and three feed edge logic
  assign sclk_fall = st_reg.pin_s3[1] & ~st_reg.pin_s2[2];
  assign sclk_rise = ~st_reg.pin_s3[1] & st_reg.pin_s2[2];
  assign cs_fall   = st_reg.pin_s3[0] & ~st_reg.pin_s2[1];
  assign cs_rise   = ~st_reg.pin_s3[0] & st_reg.pin_s2[1];

  always_comb begin
    st_next        = st_reg;
    st_next.pin_s1 = {sclk_i, scs_n_i, sdi_i};
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.pin_s3 = st_reg.pin_s2[2:1];
    st_next.done   = 1'b0;
    st_next.err    = 1'b0;
    if (cs_fall) begin
      st_next.active = 1'b1;
      st_next.cnt    = '0;
      st_next.tx     = status_byte_i;
    end else if (cs_rise && st_reg.active) begin
      st_next.active = 1'b0;
      // Short or long frames are dropped, never half applied
      if (st_reg.cnt == FRAME_CNT) begin
        st_next.done = 1'b1;
      end else begin
        st_next.err = 1'b1;
      end
    end else if (st_reg.active) begin
      if (sclk_fall) begin
        st_next.rx = {st_reg.rx[FRAME_W-2:0], st_reg.pin_s2[0]};
        if (st_reg.cnt != CNT_MAX) begin
          st_next.cnt = st_reg.cnt + 5'h01;
        end
      end
      if (sclk_rise && st_reg.cnt != '0) begin
        // Address is complete by the eighth bit, so register data follows status
        if (st_reg.cnt == STATUS_CNT) begin
          st_next.tx = rd_data_i;
        end else begin
          st_next.tx = {st_reg.tx[DATA_W-2:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg <= FRAME_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_addr_o    = st_reg.rx[ADDR_W:1];
  assign frame_done_o = st_reg.done;
  assign frame_word_o = st_reg.rx;
  assign frame_err_o  = st_reg.err;
  assign sdo_o        = sdo_push_pull_i & st_reg.tx[DATA_W-1];
  assign sdo_oe_o     = st_reg.active & (sdo_push_pull_i | ~st_reg.tx[DATA_W-1]);

  a_short_frame : assert property (@(posedge core_clk_i) disable iff (reset_i)
    (cs_rise && st_reg.active && st_reg.cnt != FRAME_CNT) |=> (frame_err_o && !frame_done_o))
    else $error("short frame not flagged");

endmodule : fsl_serial_frame

// ### rtl/fsl_fault_status_and_lock.sv
module fsl_fault_status_and_lock
  import fsl_pkg::*;
(
  input  logic              core_clk_i,
  input  logic              reset_i,
  input  logic              sleep_i,
  input  logic              thermal_warning_i,
  input  logic              thermal_shutdown_i,
  input  logic [OC_W-1:0]   switch_overcurrent_i,
  input  logic              otp_error_i,
  input  logic              step_down_overcurrent_i,
  input  logic              step_down_undervoltage_i,
  input  logic              charge_pump_low_i,
  input  logic              sclk_i,
  input  logic              scs_n_i,
  input  logic              sdi_i,
  output logic              sdo_o,
  output logic              sdo_oe_o,
  output logic [DATA_W-1:0] config_word_b_o,
  output logic [DATA_W-1:0] config_word_c_o,
  output logic [DATA_W-1:0] config_word_d_o,
  output logic [DATA_W-1:0] config_word_e_o,
  output logic [DATA_W-1:0] config_word_f_o,
  output logic [DATA_W-1:0] config_word_j_o,
  output logic              lock_active_o,
  output logic              fault_active_o
);

  fsl_regs_s            st_reg;
  fsl_regs_s            st_next;
  logic [ADDR_W-1:0]    rd_addr;
  logic [DATA_W-1:0]    rd_data;
  logic [DATA_W-1:0]    ic_status;
  logic                 frame_done;
  logic                 frame_err;
  logic [FRAME_W-1:0]   frame_word;
  logic                 wr_cmd;
  logic [ADDR_W-1:0]    wr_addr;
  logic [DATA_W-1:0]    wr_data;
  logic                 addr_bad;
  logic                 locked;
  logic                 wr_ok;
  logic                 lock_cmd;
  logic                 clear_faults;
  logic [DATA_W-1:0]    supply_events;

  fsl_serial_frame u_frame (
    .core_clk_i      (core_clk_i),
    .reset_i         (reset_i),
    .sclk_i          (sclk_i),
    .scs_n_i         (scs_n_i),
    .sdi_i           (sdi_i),
    .sdo_push_pull_i (st_reg.cfg_b[BIT_SDO_PP]),
    .status_byte_i   (ic_status),
    .rd_data_i       (rd_data),
    .rd_addr_o       (rd_addr),
    .frame_done_o    (frame_done),
    .frame_word_o    (frame_word),
    .frame_err_o     (frame_err),
    .sdo_o           (sdo_o),
    .sdo_oe_o        (sdo_oe_o)
  );

  // Only whole, correctly framed words reach here
  assign wr_cmd   = frame_done & ~frame_word[FRM_RW];
  assign wr_addr  = frame_word[FRM_ADDR_HI:FRM_ADDR_LO];
  assign wr_data  = frame_word[DATA_W-1:0];
  assign addr_bad = wr_addr > OFS_LAST;
  assign locked   = st_reg.lock_field == LOCK_LOCK;
  assign wr_ok    = wr_cmd & ~addr_bad & ~locked;
  // Lock field stays writable while locked, else it could never be released
  assign lock_cmd = wr_cmd & (wr_addr == OFS_WRITE_LOCK) &
                    (wr_data[LOCK_W-1:0] == LOCK_UNLOCK ||
                     wr_data[LOCK_W-1:0] == LOCK_LOCK);
  assign clear_faults = wr_ok & (wr_addr == OFS_CFG_B) & wr_data[BIT_CLEAR_FAULTS];

  always_comb begin
    supply_events               = '0;
    supply_events[BIT_OTP]      = st_reg.flt_s2[SW_W+3];
    supply_events[BIT_SD_OC]    = st_reg.flt_s2[SW_W+2];
    supply_events[BIT_SD_UV]    = st_reg.flt_s2[SW_W+1];
    supply_events[BIT_CP_LOW]   = st_reg.flt_s2[SW_W];
    supply_events[BIT_FRAMING]  = frame_err;
    supply_events[BIT_BAD_ADDR] = frame_done & addr_bad;
  end

  always_comb begin
    ic_status            = '0;
    ic_status[IC_BUCK]   = st_reg.supply_status[BIT_SD_OC] | st_reg.supply_status[BIT_SD_UV];
    ic_status[IC_SERIAL] = st_reg.supply_status[BIT_FRAMING] |
                           st_reg.supply_status[BIT_BAD_ADDR];
    ic_status[IC_OC]     = |st_reg.switch_status[OC_W-1:0];
    ic_status[IC_OT]     = st_reg.switch_status[BIT_TW] | st_reg.switch_status[BIT_TS];
    ic_status[IC_FAULT]  = |{st_reg.switch_status, st_reg.supply_status};
  end

  always_comb begin
    st_next        = st_reg;
    st_next.flt_s1 = {otp_error_i, step_down_overcurrent_i, step_down_undervoltage_i,
                      charge_pump_low_i, thermal_warning_i, thermal_shutdown_i,
                      switch_overcurrent_i};
    st_next.flt_s2 = st_reg.flt_s1;
    st_next.slp_s1 = sleep_i;
    st_next.slp_s2 = st_reg.slp_s1;
    // Set wins over clear, so a fault seen during the clear stays latched
    st_next.switch_status = (clear_faults ? RST_STATUS : st_reg.switch_status) |
                            st_reg.flt_s2[SW_W-1:0];
    st_next.supply_status = (clear_faults ? RST_STATUS : st_reg.supply_status) |
                            supply_events;
    if (lock_cmd) begin
      st_next.lock_field = wr_data[LOCK_W-1:0];
    end
    if (wr_ok) begin
      case (wr_addr)
        OFS_CFG_B: st_next.cfg_b = {wr_data[DATA_W-1:1], 1'b0};
        OFS_CFG_C: st_next.cfg_c = wr_data & CFG_C_WMASK;
        OFS_CFG_D: st_next.cfg_d = wr_data;
        OFS_CFG_E: st_next.cfg_e = wr_data;
        OFS_CFG_F: st_next.cfg_f = wr_data;
        OFS_CFG_J: st_next.cfg_j = wr_data;
        default: begin
          // Status and gap offsets take no writes
          st_next.cfg_b = st_reg.cfg_b;
        end
      endcase
    end
    // Sleep entry restores every register to its reset value
    if (st_reg.slp_s2) begin
      st_next.switch_status = REGS_RST.switch_status;
      st_next.supply_status = REGS_RST.supply_status;
      st_next.lock_field    = REGS_RST.lock_field;
      st_next.cfg_b         = REGS_RST.cfg_b;
      st_next.cfg_c         = REGS_RST.cfg_c;
      st_next.cfg_d         = REGS_RST.cfg_d;
      st_next.cfg_e         = REGS_RST.cfg_e;
      st_next.cfg_f         = REGS_RST.cfg_f;
      st_next.cfg_j         = REGS_RST.cfg_j;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg <= REGS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    case (rd_addr)
      OFS_IC_STATUS:     rd_data = ic_status;
      OFS_SWITCH_STATUS: rd_data = st_reg.switch_status;
      OFS_SUPPLY_STATUS: rd_data = st_reg.supply_status;
      OFS_WRITE_LOCK:    rd_data = {{(DATA_W-LOCK_W){1'b0}}, st_reg.lock_field};
      OFS_CFG_B:         rd_data = st_reg.cfg_b;
      OFS_CFG_C:         rd_data = st_reg.cfg_c;
      OFS_CFG_D:         rd_data = st_reg.cfg_d;
      OFS_CFG_E:         rd_data = st_reg.cfg_e;
      OFS_CFG_F:         rd_data = st_reg.cfg_f;
      OFS_CFG_J:         rd_data = st_reg.cfg_j;
      default:           rd_data = '0;
    endcase
  end

  assign config_word_b_o = st_reg.cfg_b;
  assign config_word_c_o = st_reg.cfg_c;
  assign config_word_d_o = st_reg.cfg_d;
  assign config_word_e_o = st_reg.cfg_e;
  assign config_word_f_o = st_reg.cfg_f;
  assign config_word_j_o = st_reg.cfg_j;
  assign lock_active_o   = locked;
  assign fault_active_o  = ic_status[IC_FAULT];

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence s_awake;
    !st_reg.slp_s2;
  endsequence

  sequence s_lock_write;
    s_awake ##0 (wr_cmd && wr_addr == OFS_WRITE_LOCK);
  endsequence

  sequence s_locked_cfg_write;
    s_awake ##0 (locked && wr_cmd && wr_addr >= OFS_CFG_B && !addr_bad);
  endsequence

  a_thermal_warn_set : assert property (
    s_awake ##0 st_reg.flt_s2[BIT_TW] |=> st_reg.switch_status[BIT_TW] ##1
    (st_reg.switch_status[BIT_TW] || $past(clear_faults) || $past(st_reg.slp_s2)))
    else $error("thermal warning not latched");

  a_thermal_shut_set : assert property (
    s_awake ##0 st_reg.flt_s2[BIT_TS] |=> st_reg.switch_status[BIT_TS])
    else $error("thermal shutdown not latched");

  a_switch_oc_set : assert property (
    s_awake ##0 (|st_reg.flt_s2[OC_W-1:0]) |=>
    ((st_reg.switch_status[OC_W-1:0] & $past(st_reg.flt_s2[OC_W-1:0])) ==
     $past(st_reg.flt_s2[OC_W-1:0])))
    else $error("switch overcurrent not latched");

  a_supply_flags_set : assert property (
    s_awake |=> ((st_reg.supply_status[BIT_OTP:BIT_CP_LOW] &
    $past(st_reg.flt_s2[RAW_W-1:SW_W])) == $past(st_reg.flt_s2[RAW_W-1:SW_W])))
    else $error("supply fault not latched");

  a_sleep_defaults : assert property (
    st_reg.slp_s2 |=> (st_reg.cfg_b == RST_CFG_B && st_reg.cfg_c == RST_CFG_C &&
    st_reg.cfg_d == RST_CFG_D && st_reg.cfg_j == RST_CFG_J &&
    st_reg.cfg_e == RST_CFG_E && st_reg.cfg_f == RST_CFG_F &&
    st_reg.supply_status == RST_STATUS &&
    st_reg.lock_field == RST_LOCK && st_reg.switch_status == RST_STATUS))
    else $error("sleep did not restore defaults");

  a_parity_reads_zero : assert property (
    (rd_addr == OFS_SUPPLY_STATUS) |-> !rd_data[BIT_PARITY] && !rd_data[DATA_W-1])
    else $error("reserved supply status bits read non-zero");

  a_framing_flag : assert property (
    s_awake ##0 frame_err |=> st_reg.supply_status[BIT_FRAMING] ##1
    (fault_active_o || $past(clear_faults) || $past(st_reg.slp_s2)))
    else $error("framing error not latched");

  a_bad_address : assert property (
    s_awake ##0 (frame_done && addr_bad) |=> st_reg.supply_status[BIT_BAD_ADDR])
    else $error("address error not latched");

  a_lock_reserved : assert property (
    (rd_addr == OFS_WRITE_LOCK) |-> (rd_data[DATA_W-1:LOCK_W] == '0))
    else $error("lock register reserved bits read non-zero");

  a_lock_other_code : assert property (
    s_lock_write ##0 (wr_data[LOCK_W-1:0] != LOCK_UNLOCK &&
    wr_data[LOCK_W-1:0] != LOCK_LOCK) |=> $stable(st_reg.lock_field))
    else $error("unknown lock code changed lock state");

  a_lock_unlock : assert property (
    s_lock_write ##0 (wr_data[LOCK_W-1:0] == LOCK_UNLOCK) |=>
    (!lock_active_o && st_reg.lock_field == LOCK_UNLOCK))
    else $error("unlock code did not unlock");

  a_lock_engage : assert property (
    s_lock_write ##0 (wr_data[LOCK_W-1:0] == LOCK_LOCK) |=> lock_active_o)
    else $error("lock code did not lock");

  // New faults may land in the same cycle, so only a dropped flag is wrong
  a_locked_ignore : assert property (
    s_locked_cfg_write |=> ($stable(st_reg.cfg_b) && $stable(st_reg.cfg_c) &&
    $stable(st_reg.cfg_d) && $stable(st_reg.cfg_e) && $stable(st_reg.cfg_f) &&
    $stable(st_reg.cfg_j) && (($past(st_reg.supply_status) & ~st_reg.supply_status) == '0)))
    else $error("write took effect while locked");

  a_clear_faults : assert property (
    s_awake ##0 (clear_faults && st_reg.flt_s2 == '0) |=>
    (st_reg.switch_status == RST_STATUS && st_reg.supply_status == RST_STATUS &&
     !st_reg.cfg_b[BIT_CLEAR_FAULTS]))
    else $error("clear faults did not clear");

  a_status_no_write : assert property (
    s_awake ##0 (wr_cmd && (wr_addr == OFS_SWITCH_STATUS || wr_addr == OFS_SUPPLY_STATUS)
    && st_reg.flt_s2 == '0) |=> ($stable(st_reg.switch_status) &&
    $stable(st_reg.supply_status)))
    else $error("status register took a write");

  a_fault_hold : assert property (
    s_awake ##0 (st_reg.switch_status[BIT_TS] && !clear_faults) |=>
    st_reg.switch_status[BIT_TS])
    else $error("latched fault dropped");

  a_supply_hold : assert property (
    s_awake ##0 (st_reg.supply_status[BIT_OTP] && !clear_faults) |=>
    st_reg.supply_status[BIT_OTP])
    else $error("latched supply fault dropped");

  a_lock_atomic : assert property (
    s_awake ##0 !(frame_done && !frame_word[FRM_RW] && wr_addr == OFS_WRITE_LOCK) |=>
    $stable(st_reg.lock_field))
    else $error("lock state changed outside a lock write");

  a_bad_addr_ignore : assert property (
    s_awake ##0 (frame_done && addr_bad) |=> ($stable(st_reg.cfg_b) &&
    $stable(st_reg.cfg_c) && $stable(st_reg.cfg_j) && $stable(st_reg.lock_field)))
    else $error("out of range access changed a register");

  a_read_no_effect : assert property (
    s_awake ##0 (frame_done && frame_word[FRM_RW]) |=> ($stable(st_reg.cfg_b) &&
    $stable(st_reg.cfg_d) && $stable(st_reg.cfg_e) && $stable(st_reg.lock_field)))
    else $error("read frame changed a register");

endmodule : fsl_fault_status_and_lock

// ### tb/fsl_spi_ctrl_model.sv
module fsl_spi_ctrl_model (
  input  wire logic core_clk_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output logic      sclk_o,
  output logic      scs_n_o,
  output logic      sdi_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sdo_line;
  // Pull-up holds the line high when not driven
  assign sdo_line = sdo_oe_i ? sdo_i : 1'b1;
  initial begin
    sclk_o = 1'b0;
    scs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : wait_clk
  // Only listed offsets are written by callers; odd lengths only on request
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] resp);
    logic [15:0] w;
    w = word;
    w[8] = ^{word[15:9], word[7:0]};
    resp = '0;
    wait_clk(1);
    scs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      sdi_o = (i < 16) ? w[15-i] : 1'b0;
      wait_clk(5);
      sclk_o = 1'b1;
      wait_clk(5);
      // Capture at the fall, since the device moves its data on the rise
      resp = {resp[14:0], sdo_line};
      sclk_o = 1'b0;
      // Data moves well after the fall so the capture never races it
      wait_clk(5);
    end
    scs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    wait_clk(8);
  endtask : xfer
endmodule : fsl_spi_ctrl_model

// ### tb/test_fsl_fault_status_and_lock.sv
module test_fsl_fault_status_and_lock
  import fsl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              core_clk, reset, sleep, tw, ts, otp, sd_oc, sd_uv, cp_low;
  logic [OC_W-1:0]   sw_oc;
  logic              sclk, scs_n, sdi, sdo, sdo_oe, lock_active, fault_active;
  logic [DATA_W-1:0] cfg [6];
  logic [15:0]       resp;
  int                n_errors, check_count;
  logic [ADDR_W-1:0] ofs [7] = '{6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h0C};
  logic [DATA_W-1:0] rst [7] = '{8'h00, 8'h60, 8'h46, 8'h10, 8'h00, 8'h00, 8'h00};

  fsl_fault_status_and_lock uut (.core_clk_i(core_clk), .reset_i(reset), .sleep_i(sleep),
    .thermal_warning_i(tw), .thermal_shutdown_i(ts), .switch_overcurrent_i(sw_oc),
    .otp_error_i(otp), .step_down_overcurrent_i(sd_oc), .step_down_undervoltage_i(sd_uv),
    .charge_pump_low_i(cp_low), .sclk_i(sclk), .scs_n_i(scs_n), .sdi_i(sdi), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .config_word_b_o(cfg[0]), .config_word_c_o(cfg[1]),
    .config_word_d_o(cfg[2]), .config_word_e_o(cfg[3]), .config_word_f_o(cfg[4]),
    .config_word_j_o(cfg[5]), .lock_active_o(lock_active), .fault_active_o(fault_active));

  fsl_spi_ctrl_model host (.core_clk_i(core_clk), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
    .sclk_o(sclk), .scs_n_o(scs_n), .sdi_o(sdi));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    host.xfer({1'b0, a, 1'b0, d}, 16, resp);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    host.xfer({1'b1, a, 1'b0, 8'h00}, 16, resp);
    check(resp[7:0], exp);
  endtask : rd
  // Pulse the detectors, then drop them so only the latch can hold the flags
  task automatic faults(input logic [7:0] sw, input logic [3:0] sup);
    {tw, ts, sw_oc} = sw;
    {otp, sd_oc, sd_uv, cp_low} = sup;
    repeat (6) @(negedge core_clk);
    {tw, ts, sw_oc} = 8'h00;
    {otp, sd_oc, sd_uv, cp_low} = 4'h0;
    repeat (6) @(negedge core_clk);
  endtask : faults
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    // About 43 frames of 249 clocks each; generous margin
    #1_000_000;
    n_errors++;
    finish_test();
  end

  initial begin
    n_errors = 0;
    check_count = 0;
    reset = 1'b1;
    sleep = 1'b0;
    {tw, ts, sw_oc} = 8'h00;
    {otp, sd_oc, sd_uv, cp_low} = 4'h0;
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    repeat (2) @(negedge core_clk);
    for (int i = 0; i < 7; i++) rd(ofs[i], rst[i]);
    for (int i = 0; i < 6; i++) check(cfg[i], rst[i+1]);
    rd(6'h01, 8'h00);
    rd(6'h02, 8'h00);
    $display("test reset_values done");
    wr(6'h07, 8'hA5);
    rd(6'h07, 8'hA5);
    wr(6'h02, 8'hFF);
    rd(6'h02, 8'h00);
    $display("test access done");
    faults(8'hA5, 4'hA);
    rd(6'h01, 8'hA5);
    rd(6'h02, 8'h50);
    check(resp[15:8], 8'h53);
    check({7'h00, fault_active}, 8'h01);
    wr(6'h04, 8'h61);
    rd(6'h04, 8'h60);
    rd(6'h01, 8'h00);
    check({7'h00, fault_active}, 8'h00);
    faults(8'h5A, 4'h5);
    rd(6'h01, 8'h5A);
    rd(6'h02, 8'h28);
    wr(6'h04, 8'h61);
    rd(6'h02, 8'h00);
    $display("test fault_flags done");
    rd(6'h20, 8'h00);
    host.xfer({1'b1, 6'h07, 1'b0, 8'h00}, 12, resp);
    rd(6'h02, 8'h03);
    check(resp[15:8], 8'h21);
    wr(6'h04, 8'h61);
    rd(6'h02, 8'h00);
    $display("test serial_errors done");
    wr(6'h03, 8'h06);
    check({7'h00, lock_active}, 8'h01);
    wr(6'h07, 8'h33);
    rd(6'h07, 8'hA5);
    wr(6'h03, 8'h05);
    rd(6'h03, 8'h06);
    check({7'h00, lock_active}, 8'h01);
    host.xfer({1'b0, 6'h03, 1'b0, 8'h03}, 17, resp);
    rd(6'h03, 8'h06);
    wr(6'h03, 8'h03);
    check({7'h00, lock_active}, 8'h00);
    wr(6'h07, 8'h33);
    rd(6'h07, 8'h33);
    wr(6'h04, 8'h40);
    rd(6'h07, 8'h33);
    rd(6'h04, 8'h40);
    $display("test lock done");
    sleep = 1'b1;
    repeat (6) @(negedge core_clk);
    sleep = 1'b0;
    repeat (4) @(negedge core_clk);
    rd(6'h07, 8'h00);
    rd(6'h03, 8'h00);
    rd(6'h02, 8'h00);
    for (int i = 0; i < 6; i++) check(cfg[i], rst[i+1]);
    $display("test sleep done");
    finish_test();
  end
endmodule : test_fsl_fault_status_and_lock
